/* rtl/rwc_pkg.sv */
// Package: register map, field layout and bus carrier types for the weekday stage
package rwc_pkg;

   // ----------------------------------------------------------------------
   // Register map (word offsets in bytes)
   // ----------------------------------------------------------------------
   localparam int          ADDR_W          = 4;
   localparam logic [3:0]  OFF_WEEKDAY     = 4'h0;
   localparam logic [3:0]  OFF_CTRL_ONE    = 4'h4;
   localparam logic [3:0]  OFF_FREE_COUNT  = 4'h8;

   // ----------------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------------
   localparam int          WD_W            = 3;
   localparam int          BUSY_BIT        = 7;
   localparam int          SRC_W           = 4;
   localparam int          SRC_LSB         = 0;
   localparam int          SOFT_RST_BIT    = 7;
   localparam int          FREE_W          = 8;

   // ----------------------------------------------------------------------
   // Values
   // ----------------------------------------------------------------------
   localparam logic [2:0]  WD_FIRST        = 3'h0;
   localparam logic [2:0]  WD_LAST         = 3'h6;
   localparam logic [2:0]  WD_RESERVED     = 3'h7;
   localparam logic [2:0]  WD_STEP         = 3'h1;
   localparam logic [3:0]  SRC_SUB_DIV4    = 4'h8;
   localparam logic [3:0]  SRC_RESET       = 4'h8;
   localparam logic [7:0]  FREE_STEP       = 8'h01;
   localparam logic [7:0]  FREE_RESET      = 8'h00;
   localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

   // ----------------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] address;
      logic [3:0]        byteenable;
      logic [31:0]       writedata;
   } rwc_av_req_type;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } rwc_av_rsp_type;

   typedef enum logic [1:0] {
      RWC_SEL_NONE    = 2'h0,
      RWC_SEL_WEEKDAY = 2'h1,
      RWC_SEL_CTRL    = 2'h2,
      RWC_SEL_FREE    = 2'h3
   } rwc_sel_type;

   typedef enum logic {
      RWC_IDLE   = 1'b0,
      RWC_UPDATE = 1'b1
   } rwc_busy_state_type;

endpackage

/* rtl/rwc_busy_window.sv */
// Update window generator: holds the busy flag while a count update ripples
`timescale 1ns/1ns
module rwc_busy_window
   import rwc_pkg::*;
#(
   parameter int BUSY_CYCLES = 4
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic clear,
   input  wire logic start,
   output logic      busy
);

   // ----------------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------------
   if (BUSY_CYCLES < 1 || BUSY_CYCLES > 255) begin : g_bad_len
      $error("BUSY_CYCLES must lie in 1..255");
   end

   localparam logic [7:0] LAST_CNT = 8'(BUSY_CYCLES - 1);

   rwc_busy_state_type state_reg, state_next;
   logic [7:0]         cnt_reg, cnt_next;

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      if (clear) begin
         state_next = RWC_IDLE;
         cnt_next   = 8'h00;
      end else begin
         case (state_reg)
            RWC_IDLE: begin
               if (start) begin
                  state_next = RWC_UPDATE;
                  cnt_next   = 8'h00;
               end
            end
            RWC_UPDATE: begin
               // A new tick inside the window restarts it
               if (start) begin
                  cnt_next = 8'h00;
               end else if (cnt_reg == LAST_CNT) begin
                  state_next = RWC_IDLE;
               end else begin
                  cnt_next = cnt_reg + 8'h01;
               end
            end
            default: begin
               state_next = RWC_IDLE;
               cnt_next   = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= RWC_IDLE;
         cnt_reg   <= 8'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   assign busy = (state_reg == RWC_UPDATE);

endmodule

/* rtl/rwc_weekday_counter.sv */
// Weekday stage of the calendar clock with its Avalon-MM register slave
`timescale 1ns/1ns
module rwc_weekday_counter
   import rwc_pkg::*;
#(
   parameter int BUSY_CYCLES = 4
) (
   input  wire logic           mclk,
   input  wire logic           rst,
   input  wire logic           count_tick,
   input  wire logic           day_carry,
   input  wire rwc_av_req_type av_req,
   output rwc_av_rsp_type      av_rsp,
   output logic                calendar_mode
);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   // Busy window counter is eight bits wide
   if (BUSY_CYCLES < 1 || BUSY_CYCLES > 255) begin : g_bad_busy
      $error("BUSY_CYCLES must lie in 1..255");
   end
   // Busy flag and every field must land inside the read word
   if (BUSY_BIT >= $bits(READ_ZERO) || WD_W > BUSY_BIT ||
       FREE_W > $bits(READ_ZERO)) begin : g_bad_layout
      $error("Register fields do not fit the read word");
   end
   // Source field and soft reset bit share the control word
   if (SRC_LSB + SRC_W > SOFT_RST_BIT || SOFT_RST_BIT >= $bits(READ_ZERO)) begin : g_bad_ctrl
      $error("Control register fields overlap");
   end
   // Refusing the reserved code only keeps the range if it lies above the last day
   if (WD_FIRST >= WD_LAST || WD_LAST >= WD_RESERVED) begin : g_bad_code
      $error("Weekday codes do not fit the field");
   end
   // Three registers need three distinct offsets
   if (OFF_WEEKDAY == OFF_CTRL_ONE || OFF_WEEKDAY == OFF_FREE_COUNT ||
       OFF_CTRL_ONE == OFF_FREE_COUNT) begin : g_bad_map
      $error("Register offsets collide");
   end

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   function automatic rwc_sel_type decode_sel(input logic [ADDR_W-1:0] addr);
      rwc_sel_type sel;
      sel = RWC_SEL_NONE;
      case (addr)
         OFF_WEEKDAY:    sel = RWC_SEL_WEEKDAY;
         OFF_CTRL_ONE:   sel = RWC_SEL_CTRL;
         OFF_FREE_COUNT: sel = RWC_SEL_FREE;
         default:        sel = RWC_SEL_NONE;
      endcase
      return sel;
   endfunction

   // Write hit on the low byte lane, decoded for both writable registers
   function automatic logic wr_hit(input logic        take,
                                   input rwc_sel_type cur,
                                   input rwc_sel_type want);
      return take & (cur == want);
   endfunction

   rwc_sel_type sel;
   logic        ack_reg, ack_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        req;
   logic        wr_take;
   logic        wr_byte0;

   assign sel      = decode_sel(av_req.address);
   assign req      = av_req.read | av_req.write;
   // One wait state: the request is taken on the edge where ack_reg is high
   assign wr_take  = av_req.write & ack_reg;
   assign wr_byte0 = wr_take & av_req.byteenable[0];

   // ----------------------------------------------------------------------
   // Control register: source select and soft reset
   // ----------------------------------------------------------------------
   logic [SRC_W-1:0] src_reg, src_next;
   logic             soft_rst_reg, soft_rst_next;

   always_comb begin
      src_next      = src_reg;
      soft_rst_next = soft_rst_reg;
      if (wr_hit(wr_byte0, sel, RWC_SEL_CTRL)) begin
         src_next      = av_req.writedata[SRC_LSB +: SRC_W];
         soft_rst_next = av_req.writedata[SOFT_RST_BIT];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         src_reg      <= SRC_RESET;
         soft_rst_reg <= 1'b0;
      end else begin
         src_reg      <= src_next;
         soft_rst_reg <= soft_rst_next;
      end
   end

   assign calendar_mode = (src_reg == SRC_SUB_DIV4);

   // ----------------------------------------------------------------------
   // Busy window
   // ----------------------------------------------------------------------
   logic busy;

   // Soft reset forces the window closed so the flag reads zero
   rwc_busy_window #(
      .BUSY_CYCLES (BUSY_CYCLES)
   ) u_busy (
      .mclk  (mclk),
      .rst   (rst),
      .clear (soft_rst_reg | ~calendar_mode),
      .start (count_tick & calendar_mode),
      .busy  (busy)
   );

   // ----------------------------------------------------------------------
   // Weekday count and free-running counter
   // ----------------------------------------------------------------------
   logic [WD_W-1:0]   wd_reg, wd_next;
   logic [FREE_W-1:0] free_reg, free_next;
   logic [WD_W-1:0]   wd_wdata;

   assign wd_wdata = av_req.writedata[WD_W-1:0];

   always_comb begin
      wd_next = wd_reg;
      if (soft_rst_reg) begin
         wd_next = WD_FIRST;
      end else if (calendar_mode && day_carry) begin
         // Hardware carry beats a software write in the same cycle
         if (wd_reg >= WD_LAST) begin
            wd_next = WD_FIRST;
         end else begin
            wd_next = wd_reg + WD_STEP;
         end
      end else if (wr_hit(wr_byte0, sel, RWC_SEL_WEEKDAY) && wd_wdata != WD_RESERVED) begin
         // The reserved code is refused so the count never leaves its range
         wd_next = wd_wdata;
      end
   end

   always_comb begin
      free_next = free_reg;
      if (soft_rst_reg) begin
         free_next = FREE_RESET;
      end else if (!calendar_mode && count_tick) begin
         free_next = free_reg + FREE_STEP;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wd_reg   <= WD_FIRST;
         free_reg <= FREE_RESET;
      end else begin
         wd_reg   <= wd_next;
         free_reg <= free_next;
      end
   end

   // ----------------------------------------------------------------------
   // Weekday read word
   // ----------------------------------------------------------------------
   function automatic logic [31:0] weekday_word(input logic            flag,
                                                input logic [WD_W-1:0] day);
      logic [31:0] rd_word;
      // Reserved bits six to three come from the zero word
      rd_word           = READ_ZERO;
      rd_word[BUSY_BIT] = flag;
      rd_word[WD_W-1:0] = day;
      return rd_word;
   endfunction

   // ----------------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------------
   always_comb begin
      ack_next   = req & ~ack_reg;
      rdata_next = rdata_reg;
      if (av_req.read && !ack_reg) begin
         rdata_next = READ_ZERO;
         case (sel)
            RWC_SEL_WEEKDAY: begin
               rdata_next = weekday_word(busy, wd_reg);
            end
            RWC_SEL_CTRL: begin
               rdata_next[SRC_LSB +: SRC_W] = src_reg;
               rdata_next[SOFT_RST_BIT]     = soft_rst_reg;
            end
            RWC_SEL_FREE: begin
               rdata_next[FREE_W-1:0] = free_reg;
            end
            default: begin
               rdata_next = READ_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ack_reg   <= 1'b0;
         rdata_reg <= READ_ZERO;
      end else begin
         ack_reg   <= ack_next;
         rdata_reg <= rdata_next;
      end
   end

   assign av_rsp.waitrequest = req & ~ack_reg;
   assign av_rsp.readdata    = rdata_reg;

endmodule

/* testbench/rwc_weekday_counter_properties.sv */
// Checker: bus timing and weekday read-back properties
`timescale 1ns/1ns
module rwc_weekday_counter_properties
   import rwc_pkg::*;
#(
   parameter int BUSY_CYCLES = 4
) (
   input wire logic           mclk,
   input wire logic           rst,
   input wire logic           count_tick,
   input wire logic           day_carry,
   input wire rwc_av_req_type av_req,
   input wire rwc_av_rsp_type av_rsp,
   input wire logic           calendar_mode
);
   // ---
   // Cycles since the last calendar tick
   // ---
   logic [7:0] since_reg;
   logic [7:0] since_next;
   always_comb begin
      since_next = since_reg;
      if (count_tick && calendar_mode)
         since_next = 8'h00;
      else if (since_reg != 8'hff)
         since_next = since_reg + 8'h01;
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         since_reg <= 8'hff;
      else
         since_reg <= since_next;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence rd_done;
      av_req.read && !av_rsp.waitrequest && av_req.address == OFF_WEEKDAY;
   endsequence
   sequence ctl_wr_done;
      av_req.write && !av_rsp.waitrequest && av_req.address == OFF_CTRL_ONE
         && av_req.byteenable[0];
   endsequence
   one_wait_a: assert property ((av_req.read || av_req.write) && av_rsp.waitrequest
      |=> !av_rsp.waitrequest) else $error("more than one wait state");
   rd_stable_a: assert property (!av_req.read |=> $stable(av_rsp.readdata))
      else $error("read data moved without a read");
   rsvd_zero_a: assert property (rd_done |-> av_rsp.readdata[6:3] == 4'h0)
      else $error("reserved weekday bits not zero");
   wd_range_a: assert property (rd_done |-> av_rsp.readdata[2:0] != WD_RESERVED)
      else $error("weekday out of range");
   busy_set_a: assert property (rd_done ##0 (since_reg >= 2 && since_reg < BUSY_CYCLES)
      |-> av_rsp.readdata[BUSY_BIT]) else $error("busy low during update");
   busy_clear_a: assert property (rd_done ##0 (since_reg > BUSY_CYCLES + 2)
      |-> !av_rsp.readdata[BUSY_BIT]) else $error("busy high when idle");
   mode_dec_a: assert property (ctl_wr_done |=> calendar_mode ==
      ($past(av_req.writedata[3:0]) == SRC_SUB_DIV4)) else $error("mode decode wrong");
   nocal_idle_a: assert property (rd_done ##0 (!calendar_mode && !$past(calendar_mode, 2))
      |-> !av_rsp.readdata[BUSY_BIT]) else $error("busy outside calendar mode");
endmodule

/* testbench/rwc_weekday_counter_tb_top.sv */
// Testbench: register traffic, carries and ticks into the weekday stage
`timescale 1ns/1ns
module rwc_weekday_counter_tb_top;
   import rwc_pkg::*;
   localparam int  BC = 4;
   logic           mclk;
   logic           rst;
   logic           count_tick;
   logic           day_carry;
   rwc_av_req_type av_req;
   rwc_av_rsp_type av_rsp;
   logic           calendar_mode;
   logic [31:0]    exp_q[$];
   int             miscompares;
   int             n_checks;
   int             seed;
   int             wd;
   int             n;
   rwc_weekday_counter #(.BUSY_CYCLES(BC)) i_rwc_weekday_counter (.mclk(mclk), .rst(rst),
      .count_tick(count_tick), .day_carry(day_carry), .av_req(av_req), .av_rsp(av_rsp),
      .calendar_mode(calendar_mode));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic end_of_test();
      if (miscompares == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic compare_read(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // ---
   // Bus master: holds the request until waitrequest is seen low
   // ---
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int t;
      t = 0;
      @(posedge mclk);
      av_req <= '{!wr, wr, a, be, d};
      do begin
         @(posedge mclk);
         t++;
      end while (av_rsp.waitrequest !== 1'b0 && t < 20);
      if (av_rsp.waitrequest !== 1'b0) begin
         miscompares++;
         end_of_test();
      end
      av_req.read <= 1'b0;
      av_req.write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0, 4'hf);
   endtask
   task automatic pulse(input bit carry, input int k);
      repeat (k) begin
         @(posedge mclk);
         if (carry)
            day_carry <= 1'b1;
         else
            count_tick <= 1'b1;
         @(posedge mclk);
         day_carry <= 1'b0;
         count_tick <= 1'b0;
      end
   endtask
   // Read data are taken at the edge where waitrequest is sampled low
   always @(posedge mclk) begin
      if (av_req.read === 1'b1 && av_rsp.waitrequest === 1'b0 && exp_q.size() > 0)
         compare_read(av_rsp.readdata, exp_q.pop_front());
   end
   initial begin
      seed = 32'h7eb9331e;
      rst = 1'b1;
      count_tick = 1'b0;
      day_carry = 1'b0;
      av_req = '0;
      miscompares = 0;
      n_checks = 0;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      rd(OFF_WEEKDAY, 32'h0);
      rd(OFF_CTRL_ONE, 32'h8);
      for (wd = 0; wd < 7; wd++) begin
         bus(1'b1, OFF_WEEKDAY, 32'(wd), 4'h1);
         rd(OFF_WEEKDAY, 32'(wd));
      end
      bus(1'b1, OFF_WEEKDAY, 32'hff, 4'h1);
      rd(OFF_WEEKDAY, 32'h6);
      bus(1'b1, OFF_WEEKDAY, 32'h2, 4'h0);
      pulse(1'b1, 1);
      rd(OFF_WEEKDAY, 32'h0);
      repeat (4) begin
         wd = $unsigned($random(seed)) % 7;
         n = $unsigned($random(seed)) % 10;
         bus(1'b1, OFF_WEEKDAY, 32'(wd), 4'h1);
         pulse(1'b1, n);
         wd = (wd + n) % 7;
         rd(OFF_WEEKDAY, 32'(wd));
      end
      pulse(1'b0, 1);
      rd(OFF_WEEKDAY, 32'h80 | 32'(wd));
      repeat (10) @(posedge mclk);
      rd(OFF_WEEKDAY, 32'(wd));
      bus(1'b1, OFF_CTRL_ONE, 32'h0, 4'h1);
      rd(OFF_CTRL_ONE, 32'h0);
      pulse(1'b1, 2);
      pulse(1'b0, 3);
      rd(OFF_WEEKDAY, 32'(wd));
      rd(OFF_FREE_COUNT, 32'h3);
      bus(1'b1, OFF_CTRL_ONE, 32'h88, 4'h1);
      pulse(1'b1, 1);
      rd(OFF_WEEKDAY, 32'h0);
      bus(1'b1, OFF_CTRL_ONE, 32'h8, 4'h1);
      bus(1'b1, 4'hc, 32'h5, 4'hf);
      rd(4'hc, 32'h0);
      pulse(1'b1, 1);
      rd(OFF_WEEKDAY, 32'h1);
      repeat (4) @(posedge mclk);
      end_of_test();
   end
endmodule
bind rwc_weekday_counter rwc_weekday_counter_properties #(.BUSY_CYCLES(BUSY_CYCLES))
   i_rwc_weekday_counter_properties (.mclk(mclk), .rst(rst), .count_tick(count_tick),
   .day_carry(day_carry), .av_req(av_req), .av_rsp(av_rsp), .calendar_mode(calendar_mode));
